/* File: core/rcr_pkg.sv */
// Purpose: Shared constants and types for the per-rail configuration and restore bank.
// Assumes: A 125 MHz internal clock and a bus engine that hands over decoded commands.
// Notes: Command codes double as register addresses, as the management bus uses them.
package rcr_pkg;

  // ********************************************************************
  // Command codes and reset values
  // ********************************************************************
  localparam logic [7:0] CMD_SLOW_OC = 8'hEC;
  localparam logic [7:0] CMD_LOOP_CFG = 8'hF0;
  localparam logic [7:0] CMD_RESTORE = 8'hF2;
  localparam logic [15:0] SLOW_OC_RESET = 16'h0606;
  localparam logic [31:0] LOOP_CFG_RESET = 32'h1020_31F6;
  localparam logic [3:0] RESTORE_ID_RESET = 4'h0;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int FILT_LSB = 8;
  localparam int DELAY_LSB = 0;
  localparam int LOOP_DE_PM3_BIT = 28;
  localparam int LOOP_MIN_PH_LSB = 8;
  localparam int LOOP_DE_EN_BIT = 6;
  localparam int LOOP_APS_BIT = 0;
  localparam logic [3:0] MIN_PHASE_MAX = 4'h9;
  localparam logic [1:0] POWER_MODE_DE = 2'h3;

  // ********************************************************************
  // Times and derived cycle counts
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned FILT_BASE_PS = 166700;
  localparam int unsigned DELAY_STEP_NS = 170700;
  localparam int unsigned RESTORE_MAX_US = 3000;
  // Least times round up, longest times round down.
  localparam int unsigned FILT_BASE_CYC = (FILT_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DELAY_STEP_CYC =
    (DELAY_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESTORE_MAX_CYC = RESTORE_MAX_US * 1000000 / CLK_PERIOD_PS;
  localparam int CNT_W = 24;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic [15:0] slow_oc;
    logic [31:0] loop_cfg;
  } rcr_rail_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] page;
    logic [31:0] wdata;
  } rcr_cmd_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [31:0] rdata;
  } rcr_rsp_t;

endpackage : rcr_pkg

/* File: core/rcr_regs.sv */
// Purpose: Per-rail slow overcurrent and loop configuration bank with user restore.
// Assumes: Commands arrive decoded, one per cycle at most, on the internal clock.
// Notes: Overcurrent and power mode inputs come from logic on the same clock.
`timescale 1ns/1ps
module rcr_regs
  import rcr_pkg::*;
#(
  parameter int NUM_RAILS = 2,
  parameter int unsigned DELAY_CYC = DELAY_STEP_CYC,
  parameter int unsigned RESTORE_CYC = RESTORE_MAX_CYC
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Decoded management commands and answers.
  input wire rcr_cmd_t i_cmd,
  output rcr_rsp_t o_rsp,
  // Stored configuration memory.
  output logic o_nvm_req,
  output logic [3:0] o_nvm_id,
  input wire logic i_nvm_valid,
  input wire rcr_rail_cfg_t [NUM_RAILS-1:0] i_nvm_cfg,
  // Restore status.
  output logic o_restore_busy,
  output logic o_restore_done,
  output logic o_restore_fail,
  // Rail control.
  input wire logic [NUM_RAILS-1:0] i_oc_over,
  input wire logic [NUM_RAILS-1:0][1:0] i_power_mode,
  output logic [NUM_RAILS-1:0] o_oc_fault,
  output logic [NUM_RAILS-1:0] o_diode_emulation,
  output logic [NUM_RAILS-1:0][3:0] o_min_phases,
  output logic [NUM_RAILS-1:0] o_auto_phase_shedding
);

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  if (NUM_RAILS < 1 || NUM_RAILS > 256) begin : g_bad_rails
    $error("NUM_RAILS must lie between 1 and 256.");
  end
  if (DELAY_CYC < 1 || DELAY_CYC > 32767 || RESTORE_CYC < 1 || RESTORE_CYC > 16000000)
  begin : g_bad_counts
    $error("Cycle count parameters out of range.");
  end

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    rcr_rail_cfg_t [NUM_RAILS-1:0] cfg;
    logic [NUM_RAILS-1:0][CNT_W-1:0] oc_cnt;
    logic [3:0] restore_id;
    logic busy;
    logic done;
    logic fail;
    logic [CNT_W-1:0] tmr;
    rcr_rsp_t rsp;
  } rcr_state_t;

  rcr_state_t state_q;
  rcr_state_t state_d;
  logic [NUM_RAILS-1:0][CNT_W-1:0] oc_limit;
  logic page_ok;
  logic [7:0] rail_sel;

  // ********************************************************************
  // Overcurrent limit per rail
  // ********************************************************************
  // Filter and delay are modelled as one persistence count: the raw overcurrent
  // must stand for the filter constant and then the delay before a fault.
  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_limit
    logic [3:0] filt_code;
    logic [7:0] dly_code;
    assign filt_code = state_q.cfg[r].slow_oc[FILT_LSB +: 4];
    assign dly_code = state_q.cfg[r].slow_oc[DELAY_LSB +: 8];
    assign oc_limit[r] = (CNT_W'(FILT_BASE_CYC) << filt_code)
      + (CNT_W'(dly_code) * CNT_W'(DELAY_CYC));
  end

  assign rail_sel = i_cmd.page;
  // Compared at nine bits so that a full bank of 256 rails still accepts every page.
  assign page_ok = ({1'b0, rail_sel} < 9'(NUM_RAILS));

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    state_d = state_q;
    state_d.rsp = '0;
    state_d.done = 1'b0;
    state_d.fail = 1'b0;
    // Persistence counters saturate at the limit and clear when current drops.
    for (int r = 0; r < NUM_RAILS; r++) begin
      if (!i_oc_over[r]) begin
        state_d.oc_cnt[r] = '0;
      end else if (state_q.oc_cnt[r] < oc_limit[r]) begin
        state_d.oc_cnt[r] = state_q.oc_cnt[r] + CNT_W'(1);
      end
    end
    // Command handling; the page picks the rail for paged registers.
    if (i_cmd.valid) begin
      state_d.rsp.valid = 1'b1;
      case (i_cmd.code)
        CMD_SLOW_OC: begin
          if (page_ok) begin
            state_d.rsp.ok = 1'b1;
            state_d.rsp.rdata = {16'h0000, state_q.cfg[rail_sel].slow_oc};
            if (i_cmd.write) begin
              state_d.cfg[rail_sel].slow_oc = i_cmd.wdata[15:0];
            end
          end
        end
        CMD_LOOP_CFG: begin
          if (page_ok) begin
            state_d.rsp.ok = 1'b1;
            // The whole word is stored so a read-modify-write keeps reserved bits.
            state_d.rsp.rdata = state_q.cfg[rail_sel].loop_cfg;
            if (i_cmd.write) begin
              state_d.cfg[rail_sel].loop_cfg = i_cmd.wdata;
            end
          end
        end
        CMD_RESTORE: begin
          state_d.rsp.rdata = {28'h000_0000, state_q.restore_id};
          if (!i_cmd.write) begin
            state_d.rsp.ok = 1'b1;
          end else if (!state_q.busy) begin
            // A restore in flight refuses a new one with ok low.
            state_d.rsp.ok = 1'b1;
            state_d.restore_id = i_cmd.wdata[3:0];
            state_d.busy = 1'b1;
            state_d.tmr = '0;
          end
        end
        default: begin
          state_d.rsp.ok = 1'b0;
        end
      endcase
    end
    // Restore engine: load on memory answer, give up at the deadline.
    if (state_q.busy) begin
      if (i_nvm_valid) begin
        state_d.cfg = i_nvm_cfg;
        state_d.busy = 1'b0;
        state_d.done = 1'b1;
      end else if (state_q.tmr >= CNT_W'(RESTORE_CYC - 1)) begin
        state_d.busy = 1'b0;
        state_d.fail = 1'b1;
      end else begin
        state_d.tmr = state_q.tmr + CNT_W'(1);
      end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        state_q.cfg[r].slow_oc <= SLOW_OC_RESET;
        state_q.cfg[r].loop_cfg <= LOOP_CFG_RESET;
      end
      state_q.oc_cnt <= '0;
      state_q.restore_id <= RESTORE_ID_RESET;
      state_q.busy <= 1'b0;
      state_q.done <= 1'b0;
      state_q.fail <= 1'b0;
      state_q.tmr <= '0;
      state_q.rsp <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Outputs decode the stored words directly, so the value is live one cycle after a write.
  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_out
    logic [31:0] lc;
    assign lc = state_q.cfg[r].loop_cfg;
    assign o_oc_fault[r] = i_oc_over[r] && (state_q.oc_cnt[r] >= oc_limit[r]);
    assign o_diode_emulation[r] = lc[LOOP_DE_EN_BIT]
      || (lc[LOOP_DE_PM3_BIT] && (i_power_mode[r] == POWER_MODE_DE));
    // Codes above nine are not allowed; clamp rather than pass them on.
    assign o_min_phases[r] = (lc[LOOP_MIN_PH_LSB +: 4] > MIN_PHASE_MAX) ?
      MIN_PHASE_MAX : lc[LOOP_MIN_PH_LSB +: 4];
    assign o_auto_phase_shedding[r] = lc[LOOP_APS_BIT];
  end

  assign o_rsp = state_q.rsp;
  assign o_nvm_req = state_q.busy;
  assign o_nvm_id = state_q.restore_id;
  assign o_restore_busy = state_q.busy;
  assign o_restore_done = state_q.done;
  assign o_restore_fail = state_q.fail;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_reset_slow_oc: assert property ($past(i_reset) |-> state_q.cfg[0].slow_oc == 16'h0606)
    else $error("Slow overcurrent word not at reset value.");
  a_reset_loop_cfg: assert property ($past(i_reset) |-> o_rsp.valid == 1'b0 &&
    state_q.cfg[0].loop_cfg == 32'h1020_31F6)
    else $error("Loop word not at reset value.");
  a_restore_upper_zero: assert property (o_rsp.valid |-> o_rsp.rdata[31:4] == 28'h0 ||
    $past(i_cmd.code) != CMD_RESTORE)
    else $error("Restore readback has upper bits set.");
  a_restore_start: assert property (i_cmd.valid && i_cmd.write && i_cmd.code == CMD_RESTORE &&
    !o_restore_busy && !i_nvm_valid |=> o_restore_busy && o_nvm_id == $past(i_cmd.wdata[3:0]))
    else $error("Restore did not start.");
  a_restore_refused: assert property (o_restore_busy && i_cmd.valid && i_cmd.write &&
    i_cmd.code == CMD_RESTORE |=> !o_rsp.ok && $stable(o_nvm_id))
    else $error("Restore accepted while busy.");
  a_restore_bound: assert property (o_restore_busy && state_q.tmr >= CNT_W'(RESTORE_CYC - 1) &&
    !i_nvm_valid |=> !o_restore_busy && o_restore_fail)
    else $error("Restore ran past its deadline.");
  a_diode_pm3: assert property (state_q.cfg[0].loop_cfg[28] && i_power_mode[0] == 2'h3
    |-> o_diode_emulation[0])
    else $error("Diode emulation missing in power mode 3.");
  a_diode_off: assert property (!state_q.cfg[0].loop_cfg[6] && i_power_mode[0] != 2'h3
    |-> !o_diode_emulation[0])
    else $error("Diode emulation on while disabled.");
  a_min_phase: assert property (o_min_phases[0] <= 4'h9)
    else $error("Minimum phase count above nine.");
  a_auto_shed: assert property (i_cmd.valid && i_cmd.write && i_cmd.code == CMD_LOOP_CFG &&
    i_cmd.page == 8'h00 && !o_restore_busy |=> o_auto_phase_shedding[0] == $past(i_cmd.wdata[0]))
    else $error("Auto phase shedding not following the loop word.");
  a_slow_oc_paged: assert property (i_cmd.valid && i_cmd.write && i_cmd.code == CMD_SLOW_OC &&
    i_cmd.page == 8'h00 && !o_restore_busy |=> $stable(state_q.cfg[NUM_RAILS-1].slow_oc) ||
    NUM_RAILS == 1)
    else $error("Slow overcurrent write reached another rail.");
  a_fault_delay: assert property ($rose(i_oc_over[0]) ##0 (oc_limit[0] > 24'd2) |->
    !o_oc_fault[0] [*2])
    else $error("Fault raised before filter time.");
  a_fault_hold: assert property (o_oc_fault[0] |-> state_q.oc_cnt[0] >= oc_limit[0])
    else $error("Fault raised before delay elapsed.");

  c_restore_done: cover property (o_restore_busy ##[1:50] o_restore_done);
  c_restore_fail: cover property (o_restore_fail);
  c_oc_fault: cover property ($rose(o_oc_fault[0]));
  c_refused: cover property (o_rsp.valid && !o_rsp.ok);

endmodule : rcr_regs

/* File: testbench/rcr_nvm_model.sv */
// Purpose: Stored configuration memory that answers restore requests.
// Assumes: Requests hold high until the bank has taken the answer.
// Notes: A silent mode never answers, so the bank must give up on its own.
`timescale 1ns/1ps
module rcr_nvm_model
  import rcr_pkg::*;
#(
  parameter int NUM_RAILS = 2
) (
  // Clock and request.
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [3:0] i_id,
  input wire logic i_silent,
  // Answer.
  output logic o_valid,
  output rcr_rail_cfg_t [NUM_RAILS-1:0] o_cfg
);
  int cnt;
  initial begin
    o_valid = 1'b0;
    cnt = 0;
  end
  // Answer five cycles into a request, once; a slow memory is the usual case.
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    if (!i_req) cnt <= 0;
    else if (!i_silent) cnt <= cnt + 1;
    if (i_req && !i_silent && cnt == 4) o_valid <= 1'b1;
  end
  // Outside the answer cycle the data is inverted so a stale capture shows.
  always_comb begin
    for (int r = 0; r < NUM_RAILS; r++) begin
      o_cfg[r] = {16'h0A00 + 16'(i_id), 32'h0000_0141 + 32'(r)};
      if (!o_valid) o_cfg[r] = ~o_cfg[r];
    end
  end
endmodule : rcr_nvm_model

/* File: testbench/rail_config_restore_regs_tb_top.sv */
// Purpose: Self-checking bench for the rail configuration and restore bank.
// Assumes: Short counts DELAY_CYC 4 and RESTORE_CYC 40.
// Notes: Commands are driven one nanosecond after the rising edge.
`timescale 1ns/1ps
module rail_config_restore_regs_tb_top
  import rcr_pkg::*;
;
  logic i_clk, i_reset, nvm_req, nvm_valid, busy, done, fail, silent;
  logic [3:0] nvm_id;
  logic [1:0] oc_over, oc_fault, de, aps;
  logic [1:0][1:0] pm;
  logic [1:0][3:0] minph;
  rcr_cmd_t cmd;
  rcr_rsp_t rsp;
  rcr_rail_cfg_t [1:0] nvm_cfg;
  int n_fail, n_tests;
  // Bank under test with short counts so the run stays brief.
  rcr_regs #(.NUM_RAILS(2), .DELAY_CYC(4), .RESTORE_CYC(40)) u_dut (.i_clk(i_clk),
    .i_reset(i_reset), .i_cmd(cmd), .o_rsp(rsp), .o_nvm_req(nvm_req), .o_nvm_id(nvm_id),
    .i_nvm_valid(nvm_valid), .i_nvm_cfg(nvm_cfg), .o_restore_busy(busy),
    .o_restore_done(done), .o_restore_fail(fail), .i_oc_over(oc_over), .i_power_mode(pm),
    .o_oc_fault(oc_fault), .o_diode_emulation(de), .o_min_phases(minph),
    .o_auto_phase_shedding(aps));
  rcr_nvm_model #(.NUM_RAILS(2)) u_nvm (.i_clk(i_clk), .i_req(nvm_req), .i_id(nvm_id),
    .i_silent(silent), .o_valid(nvm_valid), .o_cfg(nvm_cfg));
  // Clock at 125 MHz.
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One command; the answer is registered at the edge that takes it and seen just after that edge.
  task automatic bus(input logic wr, input logic [7:0] code, input logic [7:0] page,
                     input logic [31:0] wd, output logic ok, output logic [31:0] rd);
    @(posedge i_clk);
    #1 cmd = '{valid: 1'b1, write: wr, code: code, page: page, wdata: wd};
    @(posedge i_clk);
    #1 cmd.valid = 1'b0;
    chk("rsp_valid", 32'(rsp.valid), 32'h1);
    ok = rsp.ok;
    rd = rsp.rdata;
  endtask : bus
  task automatic reg_chk(input logic [7:0] code, input logic [7:0] page, input logic [31:0] exp);
    logic ok;
    logic [31:0] rd;
    bus(1'b0, code, page, 32'h0, ok, rd);
    chk("read_data", rd, exp);
  endtask : reg_chk
  // Reset values of every register; both rails for the overcurrent word, rail 1 only for the loop word.
  task automatic t_reset();
    reg_chk(CMD_SLOW_OC, 8'h00, 32'h0000_0606);
    reg_chk(CMD_SLOW_OC, 8'h01, 32'h0000_0606);
    reg_chk(CMD_LOOP_CFG, 8'h01, 32'h1020_31F6);
    reg_chk(CMD_RESTORE, 8'h00, 32'h0000_0000);
  endtask : t_reset
  // Per-rail storage, out-of-range page refused, read-modify-write of the loop word.
  task automatic t_rails();
    logic ok;
    logic [31:0] rd;
    bus(1'b1, CMD_SLOW_OC, 8'h00, 32'h0000_0100, ok, rd);
    reg_chk(CMD_SLOW_OC, 8'h00, 32'h0000_0100);
    reg_chk(CMD_SLOW_OC, 8'h01, 32'h0000_0606);
    bus(1'b0, CMD_SLOW_OC, 8'h02, 32'h0, ok, rd);
    chk("bad_page_ok", 32'(ok), 32'h0);
    bus(1'b0, CMD_LOOP_CFG, 8'h01, 32'h0, ok, rd);
    // Host keeps every other bit when changing the minimum phase count.
    bus(1'b1, CMD_LOOP_CFG, 8'h01, (rd & ~32'h0000_0F00) | 32'h0000_0F00, ok, rd);
    #1 chk("min_phase_clamp", 32'(minph[1]), 32'h9);
    chk("de_on", 32'(de[1]), 32'h1);
    chk("aps_off", 32'(aps[1]), 32'h0);
    bus(1'b1, CMD_LOOP_CFG, 8'h00, 32'h1000_0001, ok, rd);
    pm[0] = 2'h3;
    #1 chk("de_pm3", 32'(de[0]), 32'h1);
    chk("aps_on", 32'(aps[0]), 32'h1);
    chk("min_phase_zero", 32'(minph[0]), 32'h0);
    @(posedge i_clk);
    #1 pm[0] = 2'h1;
    #1 chk("de_pm1", 32'(de[0]), 32'h0);
  endtask : t_rails
  // Rail 0 gets the given word; the fault comes after lim high cycles, not before.
  task automatic t_fault(input logic [15:0] word, input int lim);
    logic ok;
    logic [31:0] rd;
    bus(1'b1, CMD_SLOW_OC, 8'h00, {16'h0000, word}, ok, rd);
    @(posedge i_clk);
    #1 oc_over[0] = 1'b1;
    repeat (lim - 1) @(posedge i_clk);
    #1 chk("fault_early", 32'(oc_fault[0]), 32'h0);
    @(posedge i_clk);
    #1 chk("fault_due", 32'(oc_fault[0]), 32'h1);
    chk("fault_other", 32'(oc_fault[1]), 32'h0);
    oc_over[0] = 1'b0;
  endtask : t_fault
  // Restore with the memory answering, then with the memory silent.
  task automatic t_restore();
    logic ok;
    logic [31:0] rd;
    int n;
    bus(1'b1, CMD_RESTORE, 8'h00, 32'h0000_00F5, ok, rd);
    chk("busy", 32'(busy), 32'h1);
    chk("nvm_req", 32'(nvm_req), 32'h1);
    chk("nvm_id", 32'(nvm_id), 32'h5);
    bus(1'b1, CMD_RESTORE, 8'h00, 32'h0000_0007, ok, rd);
    chk("busy_refused", 32'({rd[3:0], 3'h0, ok}), 32'h0000_0050);
    chk("nvm_id_kept", 32'(nvm_id), 32'h5);
    n = 0;
    while (busy === 1'b1 && n < 60) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk("done", 32'(done), 32'h1);
    chk("nvm_req_end", 32'(nvm_req), 32'h0);
    reg_chk(CMD_SLOW_OC, 8'h01, 32'h0000_0A05);
    reg_chk(CMD_LOOP_CFG, 8'h01, 32'h0000_0142);
    reg_chk(CMD_LOOP_CFG, 8'h00, 32'h0000_0141);
    reg_chk(CMD_RESTORE, 8'h00, 32'h0000_0005);
    silent = 1'b1;
    bus(1'b1, CMD_RESTORE, 8'h00, 32'h0000_0003, ok, rd);
    n = 0;
    while (fail !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk("fail_time", 32'(n >= 38 && n <= 40), 32'h1);
    @(posedge i_clk);
    #1 chk("busy_end", 32'(busy), 32'h0);
    chk("fail_pulse", 32'(fail), 32'h0);
    silent = 1'b0;
  endtask : t_restore
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    n_fail = 0;
    n_tests = 0;
    i_reset = 1'b1;
    cmd = '0;
    oc_over = '0;
    pm = '0;
    silent = 1'b0;
    repeat (16) @(posedge i_clk);
    #1 i_reset = 1'b0;
    t_reset();
    t_rails();
    // Filter 1 alone gives 21 << 1 cycles; filter 0 with delay 3 gives 21 + 3 * 4.
    t_fault(16'h0100, 42);
    t_fault(16'h0003, 33);
    t_restore();
    end_of_test();
  end
endmodule : rail_config_restore_regs_tb_top
